/* logic/bru_pkg.sv */
// package for the byte rotate unit: opcodes, widths, reset values
// assumes the core's decoder encodes rotate operations with bru_op_t
`default_nettype none
package bru_pkg;
   localparam int unsigned BRU_W        = 8;       // operand width
   localparam int unsigned BRU_MSB      = 7;       // top bit position
   localparam int unsigned BRU_LSB      = 0;       // bottom bit position
   localparam logic [7:0]  BRU_ACC_RST  = 8'h00;   // working register reset value
   localparam logic        BRU_C_RST    = 1'b0;    // carry reset value
   localparam logic [7:0]  BRU_MEM_RST  = 8'h00;   // write-back data reset value

   // rotate operations; bit 2 = right, bit 1 = via carry, bit 0 = to working
   typedef enum logic [2:0] {
      BRU_ROT_L_MEM  = 3'b000,  // rotate_left_in_place
      BRU_ROT_L_ACC  = 3'b001,  // rotate_left_to_working
      BRU_ROT_LC_MEM = 3'b010,  // rotate_left_via_flag_in_place
      BRU_ROT_LC_ACC = 3'b011,  // rotate_left_via_flag_to_working
      BRU_ROT_R_MEM  = 3'b100,  // rotate_right_in_place
      BRU_ROT_R_ACC  = 3'b101,  // rotate_right_to_working
      BRU_ROT_RC_MEM = 3'b110,  // rotate_right_via_flag_in_place
      BRU_ROT_RC_ACC = 3'b111   // rotate_right_via_flag_to_working
   } bru_op_t;
endpackage
`default_nettype wire

/* logic/bru_shifter.sv */
// combinational rotator: one-bit left or right, optionally through carry
// assumes the caller registers the results
`default_nettype none
module bru_shifter
   import bru_pkg::*;
(
   input  wire logic [7:0] operand,    // data memory operand
   input  wire logic       carry_in,   // current carry flag
   input  wire logic       dir_right,  // high rotates right
   input  wire logic       via_carry,  // high uses the 9-bit ring
   output logic      [7:0] result,     // rotated byte
   output logic            carry_out   // bit pushed out of the byte
);
   // fill bit is either the wrapped operand bit or the old carry
   wire logic fill_left  = via_carry ? carry_in : operand[BRU_MSB];
   wire logic fill_right = via_carry ? carry_in : operand[BRU_LSB];

   assign result    = dir_right ? {fill_right, operand[7:1]}
                                : {operand[6:0], fill_left};
   assign carry_out = dir_right ? operand[BRU_LSB] : operand[BRU_MSB];
endmodule // bru_shifter
`default_nettype wire

/* logic/bru_unit.sv */
// byte rotate unit top: registers working register, carry and write-back
// assumes decoder pulses op_valid for one cycle with mem_rdata valid then
// timing of one operation
// edge 0: op_valid, op and mem_rdata are sampled; the shifter settles before it
// edge 0: working_register and carry load here when the form asks for it
// edge 0: mem_we and mem_wdata launch; the memory takes them at edge 1
// a through-carry op issued right after another sees the updated carry,
// since the carry flop feeds the shifter directly with no bypass path
// limitation: a memory form followed at once by an operation on the same
// byte still reads the old byte, because the write-back lands one edge
// late; the decoder must leave a gap or forward the data itself
//
// opcode map
// bit 2 selects right, bit 1 selects the 9-bit ring through carry, and
// bit 0 selects the working register as destination instead of memory
`default_nettype none
module bru_unit
   import bru_pkg::*;
(
   input  wire logic       clk_sys,    // core clock, 250 MHz
   input  wire logic       rstn,       // synchronous reset, active low
   input  wire logic       op_valid,   // one-cycle operation strobe
   input  wire bru_op_t    op,         // rotate operation select
   input  wire logic [7:0] mem_rdata,  // operand read from data memory
   output logic      [7:0] working_register, // accumulator value
   output logic            carry,      // carry flag
   output logic      [7:0] mem_wdata,  // write-back data
   output logic            mem_we      // write-back strobe, one cycle
);
   logic [7:0] rot_result;
   logic       rot_carry;

   // op field decode; shared by the enables, the reference model and the
   // assertions; the covers still read op[0] and op[1] directly
   function automatic logic bru_is_working(input bru_op_t o);
      return o[0];
   endfunction

   function automatic logic bru_is_ring(input bru_op_t o);
      return o[1];
   endfunction

   function automatic logic bru_is_right(input bru_op_t o);
      return o[2];
   endfunction

   wire logic to_working = bru_is_working(op);
   wire logic via_carry  = bru_is_ring(op);
   wire logic dir_right  = bru_is_right(op);

   bru_shifter u_shift (
      .operand   (mem_rdata),
      .carry_in  (carry),
      .dir_right (dir_right),
      .via_carry (via_carry),
      .result    (rot_result),
      .carry_out (rot_carry)
   );

   // write enables for the three destinations
   wire logic load_acc   = op_valid & to_working;
   wire logic load_mem   = op_valid & ~to_working;
   wire logic load_carry = op_valid & via_carry;

   // working register; memory forms leave it alone
   always_ff @(posedge clk_sys) begin
      if (!rstn) working_register <= BRU_ACC_RST;
      else if (load_acc) working_register <= rot_result;
   end

   // carry only moves on through-carry forms, same edge as result
   always_ff @(posedge clk_sys) begin
      if (!rstn) carry <= BRU_C_RST;
      else if (load_carry) carry <= rot_carry;
   end

   // write-back data held registered so memory sees a clean strobe
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         mem_we    <= 1'b0;
         mem_wdata <= BRU_MEM_RST;
      end else begin
         mem_we <= load_mem;
         if (load_mem) mem_wdata <= rot_result;
      end
   end

   // reference model for the checks, written from the bit equations and not
   // from the shifter, so a slip in the shifter cannot hide itself
   function automatic logic [8:0] bru_ref(input bru_op_t    o,
                                          input logic [7:0] d,
                                          input logic       c);
      logic       fill;
      logic [7:0] res;
      logic       cout;
      fill = bru_is_ring(o) ? c : (bru_is_right(o) ? d[0] : d[7]);
      if (bru_is_right(o)) begin
         res  = {fill, d[7:1]};
         cout = d[0];
      end else begin
         res  = {d[6:0], fill};
         cout = d[7];
      end
      return {cout, res};
   endfunction

   wire logic [8:0] ref_next = bru_ref(op, mem_rdata, carry); // carry in bit 8

   // checks; per-form checks first, then checks that cut across forms
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   rl_mem_a: assert property (op_valid && op == BRU_ROT_L_MEM |=> mem_we &&
      mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && $stable(carry))
      else $error("left rotate write-back wrong");
   rl_acc_a: assert property (op_valid && op == BRU_ROT_L_ACC |=> !mem_we &&
      working_register == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && $stable(carry))
      else $error("left rotate to working wrong");
   rlc_mem_a: assert property (op_valid && op == BRU_ROT_LC_MEM |=> mem_we &&
      mem_wdata == {$past(mem_rdata[6:0]), $past(carry)} && carry == $past(mem_rdata[7]))
      else $error("left through carry wrong");
   rlc_acc_a: assert property (op_valid && op == BRU_ROT_LC_ACC |=> !mem_we &&
      working_register == {$past(mem_rdata[6:0]), $past(carry)}
      && carry == $past(mem_rdata[7]))
      else $error("left through carry to working wrong");
   rr_mem_a: assert property (op_valid && op == BRU_ROT_R_MEM |=> mem_we &&
      mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} && $stable(carry))
      else $error("right rotate write-back wrong");
   rr_acc_a: assert property (op_valid && op == BRU_ROT_R_ACC |=> !mem_we &&
      working_register == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} && $stable(carry))
      else $error("right rotate to working wrong");
   rrc_mem_a: assert property (op_valid && op == BRU_ROT_RC_MEM |=> mem_we &&
      mem_wdata == {$past(carry), $past(mem_rdata[7:1])} && carry == $past(mem_rdata[0]))
      else $error("right through carry wrong");
   rrc_acc_a: assert property (op_valid && op == BRU_ROT_RC_ACC |=> !mem_we &&
      working_register == {$past(carry), $past(mem_rdata[7:1])}
      && carry == $past(mem_rdata[0]))
      else $error("right through carry to working wrong");
   idle_hold_a: assert property (!op_valid |=> !mem_we && $stable(carry)
      && $stable(working_register))
      else $error("state changed without an operation");

   // reference model against each destination
   ref_acc_a: assert property (op_valid && to_working |=>
      working_register == $past(ref_next[7:0]))
      else $error("working register differs from reference");

   ref_mem_a: assert property (op_valid && !to_working |=>
      mem_wdata == $past(ref_next[7:0]))
      else $error("write-back differs from reference");

   ref_carry_a: assert property (op_valid && via_carry |=>
      carry == $past(ref_next[8]))
      else $error("carry differs from reference");

   // destination separation: each form touches only its own destination
   acc_keeps_mem_a: assert property (op_valid && to_working |=>
      !mem_we && $stable(mem_wdata))
      else $error("working register form touched memory");

   mem_keeps_acc_a: assert property (op_valid && !to_working |=>
      $stable(working_register))
      else $error("memory form touched the working register");

   plain_carry_a: assert property (op_valid && !via_carry |=>
      $stable(carry))
      else $error("plain rotate changed carry");

   // population of ones: both rings conserve it, a check that does not
   // lean on the bit order used above
   ring_ones_mem_a: assert property (op_valid && via_carry && !to_working |=>
      $countones({carry, mem_wdata}) == $past($countones({carry, mem_rdata})))
      else $error("memory ring lost or gained a bit");

   ring_ones_acc_a: assert property (op_valid && via_carry && to_working |=>
      $countones({carry, working_register}) == $past($countones({carry, mem_rdata})))
      else $error("working ring lost or gained a bit");

   plain_ones_a: assert property (op_valid && !via_carry && !to_working |=>
      $countones(mem_wdata) == $past($countones(mem_rdata)))
      else $error("plain rotate lost or gained a bit");

   // strobe shape: one pulse per memory form, data stands in between
   we_single_a: assert property (mem_we && !load_mem |=> !mem_we)
      else $error("write strobe longer than one cycle");

   wdata_hold_a: assert property (!load_mem |=> $stable(mem_wdata))
      else $error("write-back data moved without a memory form");

   // reset values; watched through reset itself, so nothing disables it
   reset_vals_a: assert property (@(posedge clk_sys) disable iff (1'b0)
      !rstn |=> working_register == BRU_ACC_RST && carry == BRU_C_RST
      && !mem_we && mem_wdata == BRU_MEM_RST)
      else $error("reset values wrong");

   mem_form_c: cover property (op_valid && !op[0] ##1 mem_we);
   acc_form_c: cover property (op_valid && to_working ##1 $changed(working_register));
   reset_exit_c: cover property ($rose(rstn) ##1 op_valid);
   carry_flip_c: cover property (op_valid && op[1] ##1 $changed(carry));
   back_to_back_c: cover property (op_valid ##1 op_valid ##1 op_valid);
endmodule // bru_unit
`default_nettype wire

/* verif/bru_mem_model.sv */
// data memory byte facing the rotate unit
// assumes the bench preloads it between operations
`default_nettype none
module bru_mem_model (
   input  wire logic       clk_sys,   // core clock
   input  wire logic       load,      // bench preload strobe
   input  wire logic [7:0] load_data, // preload value
   input  wire logic       mem_we,    // write-back strobe
   input  wire logic [7:0] mem_wdata, // write-back data
   output logic      [7:0] mem_rdata  // stored byte
);
   timeunit 1ns;
   timeprecision 1ps;
   // the byte only ever holds a value somebody wrote
   always_ff @(posedge clk_sys) begin
      if (load) mem_rdata <= load_data;
      else if (mem_we) mem_rdata <= mem_wdata;
   end
endmodule // bru_mem_model
`default_nettype wire

/* verif/byte_rotate_unit_bench.sv */
// bench for the byte rotate unit with a one-byte memory model
// assumes op_valid pulses are driven at the falling edge
`default_nettype none
module byte_rotate_unit_bench;
   import bru_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rstn, op_valid, load, carry, mem_we, c;
   logic [7:0] mem_rdata, mem_wdata, working_register, load_data, m, acc, r;
   bru_op_t op;
   int bad_count, total_checks;
   bru_unit dut (.clk_sys(clk_sys), .rstn(rstn), .op_valid(op_valid), .op(op),
      .mem_rdata(mem_rdata), .working_register(working_register), .carry(carry),
      .mem_wdata(mem_wdata), .mem_we(mem_we));
   bru_mem_model mem (.clk_sys(clk_sys), .load(load), .load_data(load_data),
      .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // called at a falling edge; leaves op_valid high so ops can run back to back
   task automatic do_op(input bru_op_t o);
      op_valid = 1'b1;
      op = o;
      r = o[2] ? {o[1] ? c : m[0], m[7:1]} : {m[6:0], o[1] ? c : m[7]};
      c = o[1] ? (o[2] ? m[0] : m[7]) : c;
      if (o[0]) acc = r;
      else m = r;
      @(negedge clk_sys);
      chk(8'(mem_we), 8'(!o[0]));
      if (!o[0]) chk(mem_wdata, r);
      chk(working_register, acc);
      chk(8'(carry), 8'(c));
   endtask
   task automatic preload(input logic [7:0] v);
      op_valid = 1'b0;
      load = 1'b1;
      load_data = v;
      m = v;
      @(negedge clk_sys);
      load = 1'b0;
   endtask
   // every operation on edge patterns, one at a time
   task automatic t_all_ops();
      foreach (load_data[i]) if (i < 2) for (int k = 0; k < 8; k++) begin
         preload(i ? 8'h5a : 8'h81);
         do_op(bru_op_t'(k));
      end
   endtask
   // back-to-back through-carry ops must see the updated carry
   task automatic t_back();
      preload(8'h80);
      do_op(BRU_ROT_LC_ACC);
      do_op(BRU_ROT_RC_ACC);
      do_op(BRU_ROT_LC_ACC);
      op_valid = 1'b0;
      @(negedge clk_sys);
      chk(8'(mem_we), 8'h00);
      // the write-back must land in memory one edge after the strobe
      preload(8'h01);
      do_op(BRU_ROT_RC_MEM);
      op_valid = 1'b0;
      @(negedge clk_sys);
      chk(mem_rdata, m);
   endtask
   initial begin
      {rstn, op_valid, load, c} = 4'h0;
      {load_data, acc, m} = '0;
      op = BRU_ROT_L_MEM;
      repeat (16) @(negedge clk_sys);
      rstn = 1'b1;
      chk(working_register, BRU_ACC_RST);
      t_all_ops();
      t_back();
      summarize();
   end
   // watchdog sized well past the some 56 cycles the tests need
   initial begin
      #20us;
      bad_count++;
      summarize();
   end
endmodule // byte_rotate_unit_bench
`default_nettype wire
